/* File: hdl/rx_eq_regs_cfg.svh */
// Offsets, field positions and reset values of the paged port group
`ifndef RX_EQ_REGS_CFG_SVH
`define RX_EQ_REGS_CFG_SVH
`define PAGE_SEL_ADDR      8'h4c
`define EQ_BYPASS_ADDR     8'hd4
`define EQ_LIMIT_ADDR      8'hd5
`define FILT_CLK_ADDR      8'hd6
`define FILT_DATA_ADDR     8'hd7
`define IRQ_EN_HI_ADDR     8'hd8
`define IRQ_EN_LO_ADDR     8'hd9
`define EQ_BYPASS_RST      8'h60
`define EQ_LIMIT_RST       8'hf2
`define IRQ_EN_RST         8'h00
`define PAGE_SEL_RST       8'h00
`define IRQ_EN_HI_MASK     8'h07
`define IRQ_EN_LO_MASK     8'h77
`define NUM_PORTS          4
`define STS1_EVENTS        9'h0c7
`endif

/* File: hdl/rx_eq_regs_pkg.sv */
// Types shared by the receive-port register group
package rx_eq_regs_pkg;
  typedef logic [1:0] port_idx_t;
  // Per-port write-side register set
  typedef struct packed {
    logic [7:0] bypass;
    logic [7:0] limit;
    logic [7:0] en_hi;
    logic [7:0] en_lo;
  } port_cfg_t;
  // Per-port status from the analog/link side
  typedef struct packed {
    logic       filt_maxed;
    logic       filt_stable;
    logic       filt_err;
    logic [5:0] cdly;
    logic [5:0] ddly;
    logic       adapt_done;
    logic       lock_det;
  } port_sts_t;
  // Per-port events: {enc, seq, crc, len, cnt, buf, par, pass, lock}
  typedef logic [8:0] port_evt_t;
  typedef enum logic [1:0] {IDLE, RD_HOLD} rd_state_t;
endpackage

/* File: hdl/port_cfg_mem.sv */
// Four-entry store of per-port configuration with registered read
`timescale 1ns/1ps
`include "rx_eq_regs_cfg.svh"
module port_cfg_mem
  import rx_eq_regs_pkg::*;
(
  input  wire logic      core_clk_i,
  input  wire logic      reset_i,
  input  wire logic [3:0] wr_en_i,
  input  wire logic [1:0] wr_sel_i,
  input  wire logic [7:0] wr_data_i,
  input  wire port_idx_t rd_port_i,
  output port_cfg_t      rd_data_o,
  output port_cfg_t      all_o [4]
);
  port_cfg_t mem_q [4];

  always_ff @(posedge core_clk_i) begin
    for (int p = 0; p < `NUM_PORTS; p++) begin
      if (reset_i) begin
        mem_q[p] <= {`EQ_BYPASS_RST, `EQ_LIMIT_RST, `IRQ_EN_RST, `IRQ_EN_RST};
      end else if (wr_en_i[p]) begin
        case (wr_sel_i)
          2'h0: mem_q[p].bypass <= wr_data_i;
          2'h1: mem_q[p].limit  <= wr_data_i;
          2'h2: mem_q[p].en_hi  <= wr_data_i & `IRQ_EN_HI_MASK;
          default: mem_q[p].en_lo <= wr_data_i & `IRQ_EN_LO_MASK;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rd_data_o <= {`EQ_BYPASS_RST, `EQ_LIMIT_RST, `IRQ_EN_RST, `IRQ_EN_RST};
    end else begin
      rd_data_o <= mem_q[rd_port_i];
    end
  end

  assign all_o = mem_q;
endmodule

/* File: hdl/rx_eq_regs.sv */
// Paged receive-port equalizer, filter status and interrupt enable registers
`timescale 1ns/1ps
`include "rx_eq_regs_cfg.svh"

// Summary of operation
// - Paged writes go to every port set in page bits 3:0, reads to the port in bits 5:4; each port has its own copy.
// - Bypass bit high disables adaptive equalization; resets to zero.
// - Bypassed: setting bits 5:3 come from field 7:5, reset 3.
// - Bypassed: setting bits 2:0 come from field 3:1, reset 0.
// - Lock-mode set: lock waits for adaptation; clear: lock detector only.
// - Adaptation never steps above the maximum in bits 7:4, reset 15.
// - With floor enabled, adaptation starts from floor in bits 3:0, reset 2.
// - Filter-maxed flag sets at limit, clears on read.
// - Filter-stable latches low until read, then shows live state.
// - Clock-delay value of the filter is read-only.
// - Data-delay value of the filter is read-only and live.
// - Filter-error flag sets on invalid measurement, clears on read.
// - Encoding-error enable gates an interrupt on encoding errors.
// - Sequence enable gates interrupt on control-channel sequence errors.
// - CRC enable gates an interrupt on control-channel CRC errors.
// - Line-length enable gates an interrupt on line-length change.
// - Line-count enable gates an interrupt on line-count change.
// - Buffer enable gates an interrupt on receive buffer overflow.
// - Parity enable gates an interrupt on link parity errors.
// - Port-pass enable gates an interrupt on port-valid change.
// - Lock-change enable, low register bit 0, gates lock-change interrupt.
// - Floor enable starts adaptation at floor rather than zero.
// - Pending events clear when their status register is read.
module rx_eq_regs
  import rx_eq_regs_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  output logic            reg_rvalid_o,
  input  wire logic [3:0] floor_en_i,
  input  wire logic [3:0] sts1_rd_i,
  input  wire logic [3:0] sts2_rd_i,
  input  wire port_sts_t  port_sts_i [4],
  input  wire port_evt_t  port_evt_i [4],
  input  wire logic [3:0] eq_step_up_i,
  input  wire logic [3:0] eq_restart_i,
  output logic      [3:0] eq_adapt_disable_o,
  output logic      [5:0] eq_setting_o [4],
  output logic      [3:0] rx_lock_o,
  output logic      [3:0] port_irq_o
);
  default clocking cb_core @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  // ****************************************
  // Paging and access decode
  // ****************************************
  logic [7:0]  page_q;
  port_cfg_t   rd_cfg;
  port_cfg_t   cfg [4];
  logic [3:0]  cfg_wr;
  logic [1:0]  cfg_sel;
  logic        cfg_hit;
  port_idx_t   rd_port;
  rd_state_t   rd_state_q;

  assign rd_port = page_q[5:4];

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      page_q <= `PAGE_SEL_RST;
    end else if (reg_wr_i && reg_addr_i == `PAGE_SEL_ADDR) begin
      page_q <= reg_wdata_i;
    end
  end

  always_comb begin
    cfg_hit = 1'b1;
    cfg_sel = 2'h0;
    if (reg_addr_i == `EQ_BYPASS_ADDR) begin
      cfg_sel = 2'h0;
    end else if (reg_addr_i == `EQ_LIMIT_ADDR) begin
      cfg_sel = 2'h1;
    end else if (reg_addr_i == `IRQ_EN_HI_ADDR) begin
      cfg_sel = 2'h2;
    end else if (reg_addr_i == `IRQ_EN_LO_ADDR) begin
      cfg_sel = 2'h3;
    end else begin
      cfg_hit = 1'b0;
    end
  end

  assign cfg_wr = (reg_wr_i && cfg_hit) ? page_q[3:0] : 4'h0;

  port_cfg_mem u_mem (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .wr_en_i    (cfg_wr),
    .wr_sel_i   (cfg_sel),
    .wr_data_i  (reg_wdata_i),
    .rd_port_i  (rd_port),
    .rd_data_o  (rd_cfg),
    .all_o      (cfg)
  );

  // ****************************************
  // Sampling filter status flags
  // ****************************************
  logic [3:0] maxed_q;
  logic [3:0] stable_q;
  logic [3:0] ferr_q;
  logic [3:0] rd_clk_pg;
  logic [3:0] rd_dat_pg;

  always_comb begin
    rd_clk_pg = '0;
    rd_dat_pg = '0;
    if (reg_rd_i && reg_addr_i == `FILT_CLK_ADDR) begin
      rd_clk_pg[rd_port] = 1'b1;
    end
    if (reg_rd_i && reg_addr_i == `FILT_DATA_ADDR) begin
      rd_dat_pg[rd_port] = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    for (int p = 0; p < `NUM_PORTS; p++) begin
      if (reset_i) begin
        maxed_q[p]  <= 1'b0;
        stable_q[p] <= 1'b0;
        ferr_q[p]   <= 1'b0;
      end else begin
        if (port_sts_i[p].filt_maxed) begin
          maxed_q[p] <= 1'b1;
        end else if (rd_clk_pg[p]) begin
          maxed_q[p] <= 1'b0;
        end
        if (!port_sts_i[p].filt_stable) begin
          stable_q[p] <= 1'b0;
        end else if (rd_clk_pg[p]) begin
          stable_q[p] <= 1'b1;
        end
        if (port_sts_i[p].filt_err) begin
          ferr_q[p] <= 1'b1;
        end else if (rd_dat_pg[p]) begin
          ferr_q[p] <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // Read data path
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rd_state_q   <= IDLE;
      reg_rvalid_o <= 1'b0;
    end else begin
      case (rd_state_q)
        IDLE: begin
          if (reg_rd_i) begin
            rd_state_q   <= RD_HOLD;
            reg_rvalid_o <= 1'b1;
          end
        end
        default: begin
          rd_state_q   <= reg_rd_i ? RD_HOLD : IDLE;
          reg_rvalid_o <= reg_rd_i;
        end
      endcase
    end
  end

  // Flags are captured on the read edge, before their clear lands
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      if (reg_addr_i == `PAGE_SEL_ADDR) begin
        reg_rdata_o <= page_q;
      end else if (reg_addr_i == `EQ_BYPASS_ADDR) begin
        reg_rdata_o <= rd_cfg.bypass;
      end else if (reg_addr_i == `EQ_LIMIT_ADDR) begin
        reg_rdata_o <= rd_cfg.limit;
      end else if (reg_addr_i == `FILT_CLK_ADDR) begin
        reg_rdata_o <= {maxed_q[rd_port], stable_q[rd_port],
                        port_sts_i[rd_port].cdly};
      end else if (reg_addr_i == `FILT_DATA_ADDR) begin
        reg_rdata_o <= {1'b0, ferr_q[rd_port],
                        port_sts_i[rd_port].ddly};
      end else if (reg_addr_i == `IRQ_EN_HI_ADDR) begin
        reg_rdata_o <= rd_cfg.en_hi;
      end else if (reg_addr_i == `IRQ_EN_LO_ADDR) begin
        reg_rdata_o <= rd_cfg.en_lo;
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end
  end

  // ****************************************
  // Equalizer control
  // ****************************************
  function automatic logic [3:0] eq_start(input logic [7:0] lim,
                                          input logic       fl_en);
    eq_start = fl_en ? lim[3:0] : 4'h0;
  endfunction

  logic [3:0] aeq_q [4];

  always_ff @(posedge core_clk_i) begin
    for (int p = 0; p < `NUM_PORTS; p++) begin
      if (reset_i) begin
        aeq_q[p] <= 4'h0;
      end else if (eq_restart_i[p]) begin
        aeq_q[p] <= eq_start(cfg[p].limit, floor_en_i[p]);
      end else if (eq_step_up_i[p] && aeq_q[p] < cfg[p].limit[7:4]) begin
        aeq_q[p] <= aeq_q[p] + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    for (int p = 0; p < `NUM_PORTS; p++) begin
      if (reset_i) begin
        eq_adapt_disable_o[p] <= 1'b0;
        eq_setting_o[p]       <= 6'h00;
        rx_lock_o[p]          <= 1'b0;
      end else begin
        eq_adapt_disable_o[p] <= cfg[p].bypass[0];
        if (cfg[p].bypass[0]) begin
          eq_setting_o[p] <= {cfg[p].bypass[7:5],
                              cfg[p].bypass[3:1]};
        end else begin
          eq_setting_o[p] <= {2'b00, aeq_q[p]};
        end
        rx_lock_o[p] <= port_sts_i[p].lock_det &&
                        (!cfg[p].bypass[4] || port_sts_i[p].adapt_done);
      end
    end
  end

  // ****************************************
  // Interrupt events
  // ****************************************
  logic [8:0] pend_q [4];
  logic [8:0] ev_en [4];

  always_comb begin
    for (int p = 0; p < `NUM_PORTS; p++) begin
      ev_en[p] = {cfg[p].en_hi[2:0], cfg[p].en_lo[6:4], cfg[p].en_lo[2:0]};
    end
  end

  // Mask of events cleared by status-one read: seq, crc, par, pass, lock
  localparam logic [8:0] STS1_MASK = `STS1_EVENTS;

  always_ff @(posedge core_clk_i) begin
    for (int p = 0; p < `NUM_PORTS; p++) begin
      if (reset_i) begin
        pend_q[p] <= 9'h000;
      end else begin
        pend_q[p] <= (pend_q[p]
                      & ~(sts1_rd_i[p] ? STS1_MASK : 9'h000)
                      & ~(sts2_rd_i[p] ? ~STS1_MASK : 9'h000))
                     | port_evt_i[p];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    for (int p = 0; p < `NUM_PORTS; p++) begin
      if (reset_i) begin
        port_irq_o[p] <= 1'b0;
      end else begin
        port_irq_o[p] <= |(pend_q[p] & ev_en[p]);
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_bypass_follow: assert property (
    ##1 eq_adapt_disable_o[0] == $past(cfg[0].bypass[0]))
    else $error("bypass output mismatch");
  a_manual_eq: assert property (
    cfg[0].bypass[0] |=> eq_setting_o[0] == {$past(cfg[0].bypass[7:5]),
                                               $past(cfg[0].bypass[3:1])})
    else $error("manual eq setting wrong");
  a_eq_max: assert property (
    (eq_step_up_i[0] && !eq_restart_i[0] && aeq_q[0] >= cfg[0].limit[7:4])
      |=> aeq_q[0] == $past(aeq_q[0]))
    else $error("eq stepped above maximum");
  a_floor_start: assert property (
    eq_restart_i[0] |=> aeq_q[0] == ($past(floor_en_i[0]) ?
                                     $past(cfg[0].limit[3:0]) : 4'h0))
    else $error("eq restart value wrong");
  a_lock_mode: assert property (
    (cfg[0].bypass[4] && !port_sts_i[0].adapt_done) |=> !rx_lock_o[0])
    else $error("lock before adaptation");
  a_lock_direct: assert property (
    !cfg[0].bypass[4] |=> rx_lock_o[0] == $past(port_sts_i[0].lock_det))
    else $error("lock not following detector");
  a_maxed_set: assert property (
    port_sts_i[0].filt_maxed |=> maxed_q[0])
    else $error("maxed flag not set");
  a_maxed_clear: assert property (
    (rd_clk_pg[0] && !port_sts_i[0].filt_maxed) |=> !maxed_q[0])
    else $error("maxed flag not cleared");
  a_stable_low: assert property (
    (!stable_q[0] && !rd_clk_pg[0]) |=> !stable_q[0])
    else $error("stable flag rose without read");
  a_stable_reload: assert property (
    (rd_clk_pg[0] && port_sts_i[0].filt_stable) |=> stable_q[0])
    else $error("stable flag not reloaded");
  a_ferr_set: assert property (
    port_sts_i[0].filt_err |=> ferr_q[0])
    else $error("error flag not set");
  a_ferr_clear: assert property (
    (rd_dat_pg[0] && !port_sts_i[0].filt_err) |=> !ferr_q[0])
    else $error("error flag not cleared");
  a_irq_hold: assert property (
    (|(pend_q[0] & ev_en[0])) |=> port_irq_o[0])
    else $error("interrupt missing");
  a_clear_one: assert property (
    (sts1_rd_i[0] && !port_evt_i[0][0]) |=> !pend_q[0][0])
    else $error("status-one read left event pending");
  a_clear_two: assert property (
    (sts2_rd_i[0] && !port_evt_i[0][8]) |=> !pend_q[0][8])
    else $error("status-two read left event pending");
  a_page_write: assert property (
    (cfg_wr[1] == 1'b0 && reg_wr_i && reg_addr_i == `EQ_BYPASS_ADDR)
      |=> cfg[1].bypass == $past(cfg[1].bypass))
    else $error("write reached unselected port");
  a_read_answer: assert property (
    reg_rd_i |=> reg_rvalid_o && rd_state_q == RD_HOLD)
    else $error("read answer missing");
  c_floor: cover property (eq_restart_i[0] && floor_en_i[0]);
  c_flag_read: cover property (rd_clk_pg[0] && maxed_q[0]);
  c_bypass: cover property (@(posedge core_clk_i) cfg[0].bypass[0]);
  c_irq: cover property (@(posedge core_clk_i) port_irq_o[0]);
  c_max: cover property (@(posedge core_clk_i) aeq_q[0] == cfg[0].limit[7:4]);
endmodule

/* File: testbench/link_side_model.sv */
// Link-side model: per-port status levels and event pulses
`timescale 1ns/1ps
module link_side_model
  import rx_eq_regs_pkg::*;
(
  input  wire logic      core_clk_i,
  input  wire logic      reset_i,
  input  wire port_sts_t sts_set_i [4],
  input  wire port_evt_t evt_set_i [4],
  output port_sts_t      port_sts_o [4],
  output port_evt_t      port_evt_o [4]
);
  // ****************************************
  // Launch what the bench requests on the next edge
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    for (int p = 0; p < 4; p++) begin
      port_sts_o[p] <= reset_i ? '0 : sts_set_i[p];
      port_evt_o[p] <= reset_i ? '0 : evt_set_i[p];
    end
  end
endmodule

/* File: testbench/tb_rx_eq_regs.sv */
// Self-checking bench for the paged receive-port register group
`timescale 1ns/1ps
module tb_rx_eq_regs;
  import rx_eq_regs_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] e;} row_t;
  logic       core_clk_i, reset_i, reg_wr_i, reg_rd_i, reg_rvalid_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rv, hi, lo;
  logic [3:0] floor_en_i, sts1_rd_i, sts2_rd_i, eq_step_up_i, eq_restart_i;
  logic [3:0] eq_adapt_disable_o, rx_lock_o, port_irq_o;
  logic [5:0] eq_setting_o [4];
  port_sts_t  sts_set [4], port_sts [4];
  port_evt_t  evt_set [4], port_evt [4];
  int         failures, total_checks;
  row_t       rows [8] = '{'{8'hd4, 8'hff, 8'hff}, '{8'hd4, 8'h60, 8'h60},
    '{8'hd5, 8'h5a, 8'h5a}, '{8'hd8, 8'hff, 8'h07}, '{8'hd9, 8'hff, 8'h77},
    '{8'hd9, 8'h00, 8'h00}, '{8'hd8, 8'h00, 8'h00}, '{8'he5, 8'hff, 8'h00}};

  rx_eq_regs u_rx_eq_regs (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .floor_en_i(floor_en_i),
    .sts1_rd_i(sts1_rd_i), .sts2_rd_i(sts2_rd_i), .port_sts_i(port_sts),
    .port_evt_i(port_evt), .eq_step_up_i(eq_step_up_i),
    .eq_restart_i(eq_restart_i), .eq_adapt_disable_o(eq_adapt_disable_o),
    .eq_setting_o(eq_setting_o), .rx_lock_o(rx_lock_o),
    .port_irq_o(port_irq_o));
  link_side_model u_link_side_model (.core_clk_i(core_clk_i),
    .reset_i(reset_i), .sts_set_i(sts_set), .evt_set_i(evt_set),
    .port_sts_o(port_sts), .port_evt_o(port_evt));

  // ****************************************
  // Clock and bench tasks
  // ****************************************
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  task automatic tick(input int n = 1);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    tick();
    reg_wr_i = 1'b0;
    tick();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int i;
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    tick();
    reg_rd_i = 1'b0;
    for (i = 0; i < 8 && reg_rvalid_o !== 1'b1; i++) tick();
    if (i == 8) begin
      failures++;
      $display("FAIL read answer expected 1 seen 0");
      test_done();
    end
    d = reg_rdata_o;
    tick();
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, exp);
    logic [7:0] d;
    rd(a, d);
    chk(nm, d, exp);
  endtask
  task automatic stat_rd(input bit two);
    if (two) sts2_rd_i = 4'h1;
    else sts1_rd_i = 4'h1;
    tick();
    sts1_rd_i = 4'h0;
    sts2_rd_i = 4'h0;
    tick(2);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
    {floor_en_i, sts1_rd_i, sts2_rd_i, eq_step_up_i, eq_restart_i} = '0;
    failures = 0;
    total_checks = 0;
    for (int p = 0; p < 4; p++) begin
      sts_set[p] = '0;
      evt_set[p] = '0;
    end
    reset_i = 1'b1;
    tick(4);
    reset_i = 1'b0;
    for (int p = 0; p < 4; p++) begin
      wr(8'h4c, 8'(p << 4));
      rchk("bypass reset", 8'hd4, 8'h60);
      rchk("limit reset", 8'hd5, 8'hf2);
      rchk("en hi reset", 8'hd8, 8'h00);
      rchk("en lo reset", 8'hd9, 8'h00);
    end
    $display("test reset done");
    wr(8'h4c, 8'h01);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rchk("row read", rows[i].a, rows[i].e);
    end
    $display("test table done");
    wr(8'h4c, 8'h24);
    wr(8'hd5, 8'h37);
    rchk("page own", 8'hd5, 8'h37);
    wr(8'h4c, 8'h10);
    rchk("page other", 8'hd5, 8'hf2);
    wr(8'h4c, 8'h01);
    wr(8'hd4, 8'ha5);
    tick(2);
    chk("adapt off", {4'h0, eq_adapt_disable_o}, 8'h01);
    chk("manual eq", {2'b00, eq_setting_o[0]}, 8'h2a);
    wr(8'hd4, 8'h00);
    tick(2);
    chk("adapt on", {4'h0, eq_adapt_disable_o}, 8'h00);
    $display("test bypass done");
    wr(8'hd5, 8'h31);
    floor_en_i = 4'h1;
    eq_restart_i = 4'h1;
    tick();
    eq_restart_i = 4'h0;
    tick(2);
    chk("floor start", {2'b00, eq_setting_o[0]}, 8'h01);
    repeat (4) begin
      eq_step_up_i = 4'h1;
      tick();
      eq_step_up_i = 4'h0;
      tick();
    end
    tick();
    chk("eq ceiling", {2'b00, eq_setting_o[0]}, 8'h03);
    floor_en_i = 4'h0;
    eq_restart_i = 4'h1;
    tick();
    eq_restart_i = 4'h0;
    tick(2);
    chk("zero start", {2'b00, eq_setting_o[0]}, 8'h00);
    $display("test adaptation done");
    sts_set[0].lock_det = 1'b1;
    wr(8'hd4, 8'h10);
    tick(2);
    chk("lock waits", {4'h0, rx_lock_o}, 8'h00);
    sts_set[0].adapt_done = 1'b1;
    tick(3);
    chk("lock adapted", {4'h0, rx_lock_o}, 8'h01);
    sts_set[0].adapt_done = 1'b0;
    wr(8'hd4, 8'h00);
    tick(2);
    chk("lock direct", {4'h0, rx_lock_o}, 8'h01);
    $display("test lock done");
    sts_set[0].filt_stable = 1'b1;
    sts_set[0].cdly = 6'h2b;
    sts_set[0].ddly = 6'h15;
    tick(3);
    rd(8'hd6, rv);
    chk("stable latched", rv, 8'h2b);
    rchk("filter live", 8'hd6, 8'h6b);
    sts_set[0].filt_maxed = 1'b1;
    sts_set[0].filt_stable = 1'b0;
    sts_set[0].filt_err = 1'b1;
    tick();
    sts_set[0].filt_maxed = 1'b0;
    sts_set[0].filt_stable = 1'b1;
    sts_set[0].filt_err = 1'b0;
    tick(3);
    rchk("filter flags", 8'hd6, 8'hab);
    wr(8'hd6, 8'hff);
    rchk("filter clear", 8'hd6, 8'h6b);
    rchk("meas fault", 8'hd7, 8'h55);
    rchk("fault clear", 8'hd7, 8'h15);
    $display("test filter done");
    evt_set[0] = 9'h001;
    tick();
    evt_set[0] = '0;
    tick(3);
    chk("masked irq", {4'h0, port_irq_o}, 8'h00);
    stat_rd(1'b0);
    for (int e = 0; e < 9; e++) begin
      hi = (e >= 6) ? 8'(1 << (e - 6)) : 8'h00;
      lo = (e < 6) ? 8'(1 << ((e < 3) ? e : e + 1)) : 8'h00;
      wr(8'hd8, hi);
      wr(8'hd9, lo);
      evt_set[0] = 9'(1 << e);
      tick();
      evt_set[0] = '0;
      tick(3);
      chk("irq raised", {4'h0, port_irq_o}, 8'h01);
      stat_rd(!((e == 8) || (e >= 3 && e <= 5)));
      chk("irq held", {4'h0, port_irq_o}, 8'h01);
      stat_rd((e == 8) || (e >= 3 && e <= 5));
      chk("irq cleared", {4'h0, port_irq_o}, 8'h00);
    end
    $display("test interrupts done");
    reset_i = 1'b1;
    tick(2);
    reset_i = 1'b0;
    chk("reset lock", {4'h0, rx_lock_o}, 8'h00);
    chk("reset irq", {4'h0, port_irq_o}, 8'h00);
    chk("reset setting", {2'b00, eq_setting_o[0]}, 8'h00);
    rchk("reset bypass", 8'hd4, 8'h60);
    rchk("reset page", 8'h4c, 8'h00);
    $display("test midrun reset done");
    test_done();
  end
endmodule
